// *** logic_shift_bit_alu_pkg.sv ***
// package of constants and types for the logic, shift and bit datapath
package logic_shift_bit_alu_pkg;

  // ****************************************
  // operand sizes
  // ****************************************
  localparam int DATA_W = 32;
  localparam int REG_COUNT = 8;
  localparam int REG_IDX_W = 3;
  localparam int BIT_NUM_W = 3;
  localparam int OP_W = 5;
  localparam int SIZE_W = 2;
  localparam int BYTE_MSB = 7;
  localparam int WORD_MSB = 15;
  localparam int LONG_MSB = 31;
  localparam logic [31:0] RESET_DATA = 32'h0000_0000;

  typedef enum logic [SIZE_W-1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } size_type;

  // ****************************************
  // operations
  // ****************************************
  typedef enum logic [OP_W-1:0] {
    OP_AND = 5'h00,
    OP_OR = 5'h01,
    OP_XOR = 5'h02,
    OP_NOT = 5'h03,
    OP_ARITH_SHIFT_LEFT = 5'h04,
    OP_ARITH_SHIFT_RIGHT = 5'h05,
    OP_LOGIC_SHIFT_LEFT = 5'h06,
    OP_LOGIC_SHIFT_RIGHT = 5'h07,
    OP_ROTATE_LEFT = 5'h08,
    OP_ROTATE_RIGHT = 5'h09,
    OP_ROTATE_CARRY_LEFT = 5'h0a,
    OP_ROTATE_CARRY_RIGHT = 5'h0b,
    OP_BIT_SET = 5'h0c,
    OP_BIT_CLEAR = 5'h0d,
    OP_BIT_INVERT = 5'h0e,
    OP_BIT_TEST = 5'h0f,
    OP_CARRY_AND_BIT = 5'h10,
    OP_CARRY_AND_INV_BIT = 5'h11,
    OP_CARRY_OR_BIT = 5'h12,
    OP_CARRY_OR_INV_BIT = 5'h13,
    OP_CARRY_XOR_BIT = 5'h14,
    OP_CARRY_XOR_INV_BIT = 5'h15,
    OP_BIT_TO_CARRY = 5'h16,
    OP_INV_BIT_TO_CARRY = 5'h17,
    OP_CARRY_TO_BIT = 5'h18,
    OP_INV_CARRY_TO_BIT = 5'h19
  } op_type;

endpackage : logic_shift_bit_alu_pkg

// *** logic_shift_bit_alu.sv ***
// logic, shift/rotate and bit manipulation execution datapath
`timescale 1ns/100ps
// Functional notes
// - and destination with register or immediate
// - or destination with register or immediate
// - xor destination with register or immediate
// - complement inverts every destination bit
// - arithmetic shifts write back same register
// - logical shifts write back same register
// - plain rotates stay within operand width
// - carry rotates include carry in loop
// - bit set forces selected bit high
// - bit clear forces selected bit low
// - bit invert toggles selected bit
// - bit test loads zero with inverted bit
// - bit number from immediate or register
// - inverted bit ops take immediate only
// - carry and bit, or inverted bit
// - carry or bit into carry only
// - carry or inverted bit
// - carry xor bit, operand unchanged
// - carry xor inverted bit
// - bit or inverted bit into carry
// - carry stored into selected bit
// - inverted carry stored into selected bit
// - register file with byte/word/long views
module logic_shift_bit_alu #(
  parameter int DATA_W = logic_shift_bit_alu_pkg::DATA_W,
  parameter int REG_COUNT = logic_shift_bit_alu_pkg::REG_COUNT
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [logic_shift_bit_alu_pkg::OP_W-1:0] i_op,
  input wire logic [logic_shift_bit_alu_pkg::SIZE_W-1:0] i_size,
  input wire logic [3:0] i_dst_sel,
  input wire logic [3:0] i_src_sel,
  input wire logic i_use_imm,
  input wire logic [DATA_W-1:0] i_imm,
  input wire logic i_bit_from_reg,
  input wire logic i_use_mem,
  input wire logic [7:0] i_mem_data,
  input wire logic i_reg_wr,
  input wire logic [3:0] i_reg_wr_sel,
  input wire logic [logic_shift_bit_alu_pkg::SIZE_W-1:0] i_reg_wr_size,
  input wire logic [DATA_W-1:0] i_reg_wr_data,
  input wire logic [3:0] i_rd_sel,
  input wire logic [logic_shift_bit_alu_pkg::SIZE_W-1:0] i_rd_size,
  output logic [DATA_W-1:0] o_rd_data,
  output logic [DATA_W-1:0] o_result,
  output logic o_done,
  output logic o_illegal,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wr_data,
  output logic o_carry,
  output logic o_zero
);

  // ****************************************
  // register file
  // ****************************************
  // selector: bit 3 picks the upper half view (high byte or upper word)
  logic [DATA_W-1:0] regs_q [REG_COUNT];
  logic carry_q, zero_q;

  // sized read of a general register through its byte, word or long view
  function automatic logic [31:0] view_read(input logic [31:0] r, input logic [1:0] sz,
                                            input logic hi);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (sz)
      logic_shift_bit_alu_pkg::SIZE_BYTE: v[7:0] = hi ? r[15:8] : r[7:0];
      logic_shift_bit_alu_pkg::SIZE_WORD: v[15:0] = hi ? r[31:16] : r[15:0];
      default: v = r;
    endcase
    return v;
  endfunction : view_read

  // merge a sized value back into its register, leaving the rest intact
  function automatic logic [31:0] view_write(input logic [31:0] r, input logic [1:0] sz,
                                             input logic hi, input logic [31:0] d);
    logic [31:0] v;
    v = r;
    case (sz)
      logic_shift_bit_alu_pkg::SIZE_BYTE:
      begin
        if (hi)
          v[15:8] = d[7:0];
        else
          v[7:0] = d[7:0];
      end
      logic_shift_bit_alu_pkg::SIZE_WORD:
      begin
        if (hi)
          v[31:16] = d[15:0];
        else
          v[15:0] = d[15:0];
      end
      default: v = d;
    endcase
    return v;
  endfunction : view_write

  // index of the sign bit for the operand size
  function automatic logic [4:0] msb_of(input logic [1:0] sz);
    case (sz)
      logic_shift_bit_alu_pkg::SIZE_BYTE: msb_of = 5'(logic_shift_bit_alu_pkg::BYTE_MSB);
      logic_shift_bit_alu_pkg::SIZE_WORD: msb_of = 5'(logic_shift_bit_alu_pkg::WORD_MSB);
      default: msb_of = 5'(logic_shift_bit_alu_pkg::LONG_MSB);
    endcase
  endfunction : msb_of

  // ****************************************
  // operand fetch
  // ****************************************
  logic [31:0] dst_val;
  logic [31:0] src_val;
  logic [31:0] operand_b;
  logic [7:0] dst_byte, src_byte;
  logic [7:0] bit_byte;
  logic [2:0] bit_num;
  logic [4:0] msb;
  logic sel_bit;
  logic inv_op;
  logic bad_size;

  always_comb
  begin
    dst_val = view_read(regs_q[i_dst_sel[2:0]], i_size, i_dst_sel[3]);
    src_val = view_read(regs_q[i_src_sel[2:0]], i_size, i_src_sel[3]);
    operand_b = i_use_imm ? view_read(i_imm, i_size, 1'b0) : src_val;
    msb = msb_of(i_size);
    dst_byte = i_dst_sel[3] ? regs_q[i_dst_sel[2:0]][15:8] : regs_q[i_dst_sel[2:0]][7:0];
    src_byte = i_src_sel[3] ? regs_q[i_src_sel[2:0]][15:8] : regs_q[i_src_sel[2:0]][7:0];
    bit_byte = i_use_mem ? i_mem_data : dst_byte;
    bit_num = i_bit_from_reg ? src_byte[2:0] : i_imm[2:0];
    sel_bit = bit_byte[bit_num];
  end

  // inverted-operand forms only accept an immediate bit number
  always_comb
  begin
    case (logic_shift_bit_alu_pkg::op_type'(i_op))
      logic_shift_bit_alu_pkg::OP_CARRY_AND_INV_BIT,
      logic_shift_bit_alu_pkg::OP_CARRY_OR_INV_BIT,
      logic_shift_bit_alu_pkg::OP_CARRY_XOR_INV_BIT,
      logic_shift_bit_alu_pkg::OP_INV_BIT_TO_CARRY,
      logic_shift_bit_alu_pkg::OP_INV_CARRY_TO_BIT: inv_op = 1'b1;
      default: inv_op = 1'b0;
    endcase
    bad_size = (i_size == 2'h3);
  end

  // ****************************************
  // execute
  // ****************************************
  logic [31:0] res_d;
  logic carry_d;
  logic zero_d;
  logic reg_wb_d;
  logic mem_wb_d;
  logic illegal_d;
  logic [7:0] mask;

  always_comb
  begin
    res_d = dst_val;
    carry_d = carry_q;
    zero_d = zero_q;
    reg_wb_d = 1'b0;
    mem_wb_d = 1'b0;
    illegal_d = 1'b0;
    mask = 8'h01 << bit_num;
    case (logic_shift_bit_alu_pkg::op_type'(i_op))
      logic_shift_bit_alu_pkg::OP_AND:
      begin
        res_d = dst_val & operand_b;
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_OR:
      begin
        res_d = dst_val | operand_b;
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_XOR:
      begin
        res_d = dst_val ^ operand_b;
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_NOT:
      begin
        res_d = ~dst_val;
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_ARITH_SHIFT_LEFT,
      logic_shift_bit_alu_pkg::OP_LOGIC_SHIFT_LEFT:
      begin
        res_d = dst_val << 1;
        carry_d = dst_val[msb];
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_ARITH_SHIFT_RIGHT:
      begin
        res_d = dst_val >> 1;
        res_d[msb] = dst_val[msb];
        carry_d = dst_val[0];
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_LOGIC_SHIFT_RIGHT:
      begin
        res_d = dst_val >> 1;
        carry_d = dst_val[0];
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_ROTATE_LEFT:
      begin
        res_d = dst_val << 1;
        res_d[0] = dst_val[msb];
        carry_d = dst_val[msb];
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_ROTATE_RIGHT:
      begin
        res_d = dst_val >> 1;
        res_d[msb] = dst_val[0];
        carry_d = dst_val[0];
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_ROTATE_CARRY_LEFT:
      begin
        res_d = dst_val << 1;
        res_d[0] = carry_q;
        carry_d = dst_val[msb];
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_ROTATE_CARRY_RIGHT:
      begin
        res_d = dst_val >> 1;
        res_d[msb] = carry_q;
        carry_d = dst_val[0];
        reg_wb_d = 1'b1;
      end
      logic_shift_bit_alu_pkg::OP_BIT_SET:
      begin
        res_d = {24'h00_0000, bit_byte | mask};
        reg_wb_d = !i_use_mem;
        mem_wb_d = i_use_mem;
      end
      logic_shift_bit_alu_pkg::OP_BIT_CLEAR:
      begin
        res_d = {24'h00_0000, bit_byte & ~mask};
        reg_wb_d = !i_use_mem;
        mem_wb_d = i_use_mem;
      end
      logic_shift_bit_alu_pkg::OP_BIT_INVERT:
      begin
        res_d = {24'h00_0000, bit_byte ^ mask};
        reg_wb_d = !i_use_mem;
        mem_wb_d = i_use_mem;
      end
      logic_shift_bit_alu_pkg::OP_BIT_TEST:
      begin
        zero_d = !sel_bit;
        res_d = {24'h00_0000, bit_byte};
      end
      logic_shift_bit_alu_pkg::OP_CARRY_AND_BIT: carry_d = carry_q & sel_bit;
      logic_shift_bit_alu_pkg::OP_CARRY_AND_INV_BIT: carry_d = carry_q & !sel_bit;
      logic_shift_bit_alu_pkg::OP_CARRY_OR_BIT: carry_d = carry_q | sel_bit;
      logic_shift_bit_alu_pkg::OP_CARRY_OR_INV_BIT: carry_d = carry_q | !sel_bit;
      logic_shift_bit_alu_pkg::OP_CARRY_XOR_BIT: carry_d = carry_q ^ sel_bit;
      logic_shift_bit_alu_pkg::OP_CARRY_XOR_INV_BIT: carry_d = carry_q ^ !sel_bit;
      logic_shift_bit_alu_pkg::OP_BIT_TO_CARRY: carry_d = sel_bit;
      logic_shift_bit_alu_pkg::OP_INV_BIT_TO_CARRY: carry_d = !sel_bit;
      logic_shift_bit_alu_pkg::OP_CARRY_TO_BIT:
      begin
        res_d = {24'h00_0000, carry_q ? (bit_byte | mask) : (bit_byte & ~mask)};
        reg_wb_d = !i_use_mem;
        mem_wb_d = i_use_mem;
      end
      logic_shift_bit_alu_pkg::OP_INV_CARRY_TO_BIT:
      begin
        res_d = {24'h00_0000, carry_q ? (bit_byte & ~mask) : (bit_byte | mask)};
        reg_wb_d = !i_use_mem;
        mem_wb_d = i_use_mem;
      end
      default: illegal_d = 1'b1;
    endcase
    // register bit number not allowed on inverted forms; size 3 undefined
    illegal_d = illegal_d || (inv_op && i_bit_from_reg) || bad_size;
    if (illegal_d)
    begin
      res_d = dst_val;
      carry_d = carry_q;
      zero_d = zero_q;
      reg_wb_d = 1'b0;
      mem_wb_d = 1'b0;
    end
  end

  logic [1:0] wb_size;
  assign wb_size = mem_wb_d ? logic_shift_bit_alu_pkg::SIZE_BYTE :
                   (i_op >= 5'(logic_shift_bit_alu_pkg::OP_BIT_SET)) ?
                   logic_shift_bit_alu_pkg::SIZE_BYTE : i_size;

  // ****************************************
  // state update
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs_q[i] <= logic_shift_bit_alu_pkg::RESET_DATA;
    end
    else if (i_start && reg_wb_d)
    begin
      regs_q[i_dst_sel[2:0]] <= view_write(regs_q[i_dst_sel[2:0]], wb_size, i_dst_sel[3],
                                           res_d);
    end
    else if (i_reg_wr)
    begin
      regs_q[i_reg_wr_sel[2:0]] <= view_write(regs_q[i_reg_wr_sel[2:0]], i_reg_wr_size,
                                              i_reg_wr_sel[3], i_reg_wr_data);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      carry_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (i_start)
    begin
      carry_q <= carry_d;
      zero_q <= zero_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_result <= logic_shift_bit_alu_pkg::RESET_DATA;
      o_done <= 1'b0;
      o_illegal <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_wr_data <= 8'h00;
      o_rd_data <= logic_shift_bit_alu_pkg::RESET_DATA;
    end
    else
    begin
      o_done <= i_start;
      o_illegal <= i_start && illegal_d;
      o_mem_wr <= i_start && mem_wb_d;
      if (i_start)
      begin
        o_result <= view_read(res_d, wb_size, 1'b0);
        o_mem_wr_data <= res_d[7:0];
      end
      o_rd_data <= view_read(regs_q[i_rd_sel[2:0]], i_rd_size, i_rd_sel[3]);
    end
  end

  assign o_carry = carry_q;
  assign o_zero = zero_q;
endmodule : logic_shift_bit_alu

// *** logic_shift_bit_alu_asserts.sv ***
// checker for the logic, shift and bit datapath
`timescale 1ns/100ps
module logic_shift_bit_alu_asserts #(
  parameter int DATA_W = 32
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [4:0] i_op,
  input wire logic [1:0] i_size,
  input wire logic [DATA_W-1:0] i_imm,
  input wire logic i_bit_from_reg,
  input wire logic i_use_mem,
  input wire logic [7:0] i_mem_data,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire logic o_mem_wr,
  input wire logic [7:0] o_mem_wr_data,
  input wire logic o_carry,
  input wire logic o_zero
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_mem(logic [4:0] op);
    i_start && i_op == op && i_use_mem && !i_bit_from_reg && i_size != 2'h3;
  endsequence
  property p_logic_flags;
    i_start && i_op <= 5'h03 && i_size != 2'h3 |=> o_done && $stable(o_carry) && $stable(o_zero);
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logic op moved flags");
  property p_carry_only;
    s_mem(5'h12) or s_mem(5'h14) |=> o_done && !o_mem_wr;
  endproperty
  a_carry_only: assert property (p_carry_only) else $error("carry op wrote operand");
  property p_load;
    s_mem(5'h16) |=> o_carry == $past(i_mem_data[i_imm[2:0]]);
  endproperty
  a_load: assert property (p_load) else $error("bit load wrong");
  property p_inv_load;
    s_mem(5'h17) |=> o_carry == !$past(i_mem_data[i_imm[2:0]]);
  endproperty
  a_inv_load: assert property (p_inv_load) else $error("inverse bit load wrong");
  property p_or;
    s_mem(5'h12) |=> o_carry == ($past(o_carry) | $past(i_mem_data[i_imm[2:0]]));
  endproperty
  a_or: assert property (p_or) else $error("carry or wrong");
  property p_xor_inv;
    s_mem(5'h15) |=> o_carry == ($past(o_carry) ^ !$past(i_mem_data[i_imm[2:0]]));
  endproperty
  a_xor_inv: assert property (p_xor_inv) else $error("carry xor inverse wrong");
  property p_test;
    s_mem(5'h0f) |=> o_zero == !$past(i_mem_data[i_imm[2:0]]) && !o_mem_wr;
  endproperty
  a_test: assert property (p_test) else $error("bit test wrong");
  property p_set;
    s_mem(5'h0c) |=> o_mem_wr && o_mem_wr_data == ($past(i_mem_data) | (8'h01 << $past(i_imm[2:0])));
  endproperty
  a_set: assert property (p_set) else $error("bit set wrong");
  property p_store;
    s_mem(5'h18) |=> o_mem_wr && o_mem_wr_data[$past(i_imm[2:0])] == $past(o_carry);
  endproperty
  a_store: assert property (p_store) else $error("carry store wrong");
  property p_inv_reg;
    i_start && i_bit_from_reg && i_op inside {5'h11, 5'h13, 5'h15, 5'h17, 5'h19}
      |=> o_illegal && $stable(o_carry);
  endproperty
  a_inv_reg: assert property (p_inv_reg) else $error("inverse op took register bit");
  property p_bad_size;
    i_start && i_op <= 5'h0b && i_size == 2'h3 |=> o_illegal && !o_mem_wr;
  endproperty
  a_bad_size: assert property (p_bad_size) else $error("bad size accepted");
endmodule : logic_shift_bit_alu_asserts

bind logic_shift_bit_alu logic_shift_bit_alu_asserts #(.DATA_W(DATA_W)) logic_shift_bit_alu_asserts_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_start(i_start), .i_op(i_op), .i_size(i_size),
  .i_imm(i_imm), .i_bit_from_reg(i_bit_from_reg), .i_use_mem(i_use_mem),
  .i_mem_data(i_mem_data), .o_done(o_done), .o_illegal(o_illegal), .o_mem_wr(o_mem_wr),
  .o_mem_wr_data(o_mem_wr_data), .o_carry(o_carry), .o_zero(o_zero));

// *** logic_shift_bit_alu_tb_top.sv ***
// self-checking testbench for the logic, shift and bit datapath
`timescale 1ns/100ps
module logic_shift_bit_alu_tb_top;
  logic i_clk, i_sys_rst, i_start, i_use_imm, i_bit_from_reg, i_use_mem, i_reg_wr;
  logic [4:0] i_op;
  logic [1:0] i_size, i_reg_wr_size, i_rd_size;
  logic [3:0] i_dst_sel, i_src_sel, i_reg_wr_sel, i_rd_sel;
  logic [31:0] i_imm, i_reg_wr_data, o_rd_data, o_result;
  logic [7:0] i_mem_data, o_mem_wr_data;
  logic o_done, o_illegal, o_mem_wr, o_carry, o_zero;
  int errors = 0;
  int checks = 0;

  logic_shift_bit_alu logic_shift_bit_alu_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_start(i_start), .i_op(i_op), .i_size(i_size),
    .i_dst_sel(i_dst_sel), .i_src_sel(i_src_sel), .i_use_imm(i_use_imm), .i_imm(i_imm),
    .i_bit_from_reg(i_bit_from_reg), .i_use_mem(i_use_mem), .i_mem_data(i_mem_data),
    .i_reg_wr(i_reg_wr), .i_reg_wr_sel(i_reg_wr_sel), .i_reg_wr_size(i_reg_wr_size),
    .i_reg_wr_data(i_reg_wr_data), .i_rd_sel(i_rd_sel), .i_rd_size(i_rd_size),
    .o_rd_data(o_rd_data), .o_result(o_result), .o_done(o_done), .o_illegal(o_illegal),
    .o_mem_wr(o_mem_wr), .o_mem_wr_data(o_mem_wr_data), .o_carry(o_carry), .o_zero(o_zero));

  // ****************
  // helpers
  // ****************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] sel, input logic [1:0] sz, input logic [31:0] d);
    @(negedge i_clk);
    i_reg_wr = 1'b1;
    i_reg_wr_sel = sel;
    i_reg_wr_size = sz;
    i_reg_wr_data = d;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] sel, output logic [31:0] d);
    @(negedge i_clk);
    i_rd_sel = sel;
    i_rd_size = 2'h2;
    @(negedge i_clk);
    d = o_rd_data;
  endtask : rd_reg

  // md packs use_imm, bit_from_reg, use_mem
  task automatic exec(input logic [4:0] op, input logic [1:0] sz, input logic [3:0] dst,
                      input logic [3:0] src, input logic [31:0] imm, input logic [2:0] md,
                      input logic [7:0] mem);
    @(negedge i_clk);
    i_start = 1'b1;
    i_op = op;
    i_size = sz;
    i_dst_sel = dst;
    i_src_sel = src;
    i_imm = imm;
    {i_use_imm, i_bit_from_reg, i_use_mem} = md;
    i_mem_data = mem;
    @(negedge i_clk);
    i_start = 1'b0;
    chk("done", {31'h0, o_done}, 32'h1);
  endtask : exec

  task automatic set_carry(input logic c);
    exec(5'h16, 2'h0, 4'h0, 4'h0, 32'h0, 3'b001, {7'h0, c});
  endtask : set_carry

  function automatic logic carry_exp(input logic [4:0] op, input logic c, input logic b);
    case (op)
      5'h10: return c & b;
      5'h11: return c & ~b;
      5'h12: return c | b;
      5'h13: return c | ~b;
      5'h14: return c ^ b;
      5'h15: return c ^ ~b;
      5'h16: return b;
      default: return ~b;
    endcase
  endfunction : carry_exp

  task automatic shift_case(input logic [4:0] op, input logic [1:0] sz, input logic [31:0] v,
                            input logic cin, input logic [31:0] r, input logic cout);
    logic [31:0] d;
    logic [31:0] rv;
    wr_reg(4'h3, 2'h2, v);
    set_carry(cin);
    exec(op, sz, 4'h3, 4'h0, 32'h0, 3'b000, 8'h00);
    rd_reg(4'h3, d);
    chk("shift_value", d, r);
    chk("shift_carry", {31'h0, o_carry}, {31'h0, cout});
    rv = (sz == 2'h0) ? {24'h0, r[7:0]} : ((sz == 2'h1) ? {16'h0, r[15:0]} : r);
    chk("shift_result", o_result, rv);
  endtask : shift_case

  task automatic mem_case(input logic [4:0] op, input logic [7:0] m, input logic [2:0] b,
                          input logic [7:0] e);
    exec(op, 2'h0, 4'h0, 4'h0, {29'h0, b}, 3'b001, m);
    chk("mem_wr", {31'h0, o_mem_wr}, 32'h1);
    chk("mem_data", {24'h0, o_mem_wr_data}, {24'h0, e});
  endtask : mem_case

  // ****************
  // scenarios
  // ****************
  task automatic t_logic;
    logic [31:0] d;
    wr_reg(4'h1, 2'h2, 32'h1234_5678);
    wr_reg(4'h2, 2'h2, 32'h0f0f_f0f0);
    exec(5'h00, 2'h0, 4'h1, 4'h0, 32'h0000_000f, 3'b100, 8'h00);
    rd_reg(4'h1, d);
    chk("and_byte", d, 32'h1234_5608);
    chk("and_result", o_result, 32'h0000_0008);
    exec(5'h01, 2'h1, 4'h9, 4'h2, 32'h0, 3'b000, 8'h00);
    rd_reg(4'h1, d);
    chk("or_word_high", d, 32'hf2f4_5608);
    exec(5'h02, 2'h2, 4'h1, 4'h0, 32'hffff_0000, 3'b100, 8'h00);
    rd_reg(4'h1, d);
    chk("xor_long", d, 32'h0d0b_5608);
    chk("xor_result", o_result, 32'h0d0b_5608);
    exec(5'h03, 2'h0, 4'h9, 4'h0, 32'h0, 3'b000, 8'h00);
    rd_reg(4'h1, d);
    chk("not_byte_high", d, 32'h0d0b_a908);
    chk("not_result", o_result, 32'h0000_00a9);
    $display("test logic finished");
  endtask : t_logic

  task automatic t_shift;
    shift_case(5'h04, 2'h0, 32'hffff_ff41, 1'b0, 32'hffff_ff82, 1'b0);
    shift_case(5'h05, 2'h0, 32'h0000_0082, 1'b0, 32'h0000_00c1, 1'b0);
    shift_case(5'h05, 2'h1, 32'h1111_8001, 1'b0, 32'h1111_c000, 1'b1);
    shift_case(5'h06, 2'h0, 32'h0000_0081, 1'b0, 32'h0000_0002, 1'b1);
    shift_case(5'h07, 2'h2, 32'h8000_0002, 1'b1, 32'h4000_0001, 1'b0);
    shift_case(5'h08, 2'h0, 32'h0000_0081, 1'b0, 32'h0000_0003, 1'b1);
    shift_case(5'h09, 2'h1, 32'h0000_0001, 1'b0, 32'h0000_8000, 1'b1);
    shift_case(5'h0a, 2'h0, 32'h0000_0040, 1'b1, 32'h0000_0081, 1'b0);
    shift_case(5'h0b, 2'h2, 32'h0000_0002, 1'b1, 32'h8000_0001, 1'b0);
    shift_case(5'h0b, 2'h0, 32'h0000_0001, 1'b0, 32'h0000_0000, 1'b1);
    $display("test shift finished");
  endtask : t_shift

  task automatic t_bits;
    logic [31:0] d;
    mem_case(5'h0c, 8'ha5, 3'h1, 8'ha7);
    mem_case(5'h0d, 8'ha5, 3'h0, 8'ha4);
    mem_case(5'h0e, 8'ha5, 3'h7, 8'h25);
    set_carry(1'b1);
    mem_case(5'h18, 8'ha5, 3'h1, 8'ha7);
    mem_case(5'h19, 8'ha7, 3'h1, 8'ha5);
    wr_reg(4'h4, 2'h2, 32'h0);
    wr_reg(4'h5, 2'h0, 32'h0000_00fd);
    exec(5'h0c, 2'h0, 4'h4, 4'h5, 32'h0, 3'b010, 8'h00);
    rd_reg(4'h4, d);
    chk("set_reg_bit", d, 32'h0000_0020);
    // bit ops on a register use its byte view for any size field except the undefined size 3
    exec(5'h0c, 2'h1, 4'hc, 4'h0, 32'h0, 3'b000, 8'h00);
    rd_reg(4'h4, d);
    chk("set_reg_high", d, 32'h0000_0120);
    exec(5'h0f, 2'h0, 4'h4, 4'h0, 32'h5, 3'b000, 8'h00);
    chk("test_one", {31'h0, o_zero}, 32'h0);
    chk("test_result", o_result, 32'h0000_0020);
    exec(5'h0f, 2'h0, 4'h0, 4'h0, 32'h3, 3'b001, 8'h10);
    chk("test_zero", {31'h0, o_zero}, 32'h1);
    // bit 4 of the byte is one, bit 5 zero
    for (int op = 16; op < 24; op++)
      for (int k = 0; k < 4; k++)
      begin
        set_carry(k[0]);
        exec(op[4:0], 2'h0, 4'h0, 4'h0, {29'h0, 2'b10, k[1]}, 3'b001, 8'h10);
        chk("carry_op", {31'h0, o_carry}, {31'h0, carry_exp(op[4:0], k[0], ~k[1])});
        chk("carry_op_wr", {31'h0, o_mem_wr}, 32'h0);
      end
    $display("test bits finished");
  endtask : t_bits

  task automatic t_illegal;
    logic [31:0] d;
    exec(5'h00, 2'h3, 4'h1, 4'h0, 32'h0, 3'b100, 8'h00);
    chk("bad_size", {31'h0, o_illegal}, 32'h1);
    rd_reg(4'h1, d);
    chk("bad_size_reg", d, 32'h0d0b_a908);
    set_carry(1'b0);
    exec(5'h13, 2'h0, 4'h0, 4'h5, 32'h0, 3'b011, 8'h00);
    chk("inv_from_reg", {30'h0, o_illegal, o_carry}, 32'h2);
    $display("test illegal finished");
  endtask : t_illegal

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial
  begin
    {i_sys_rst, i_start, i_use_imm, i_bit_from_reg, i_use_mem, i_reg_wr} = 6'h20;
    {i_op, i_size, i_reg_wr_size, i_rd_size} = 11'h0;
    {i_dst_sel, i_src_sel, i_reg_wr_sel, i_rd_sel} = 16'h0;
    {i_imm, i_reg_wr_data, i_mem_data} = 72'h0;
    repeat (12) @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_logic;
    t_shift;
    t_bits;
    t_illegal;
    end_of_test;
  end

  initial
  begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule : logic_shift_bit_alu_tb_top
